// *** core/cdf_halver.sv ***
// One cascade section: averages sample pairs, emits one per two inputs.
// Assumes a synchronous flush while the acquisition is idle.
`timescale 1ns/1ps
module cdf_halver (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic flush,
   input wire logic in_valid,
   input cdf_pkg::cdf_smp_t in_smp,
   output logic out_valid,
   output cdf_pkg::cdf_smp_t out_smp
);
   logic phase_r;
   cdf_pkg::cdf_smp_t first_r;
   logic signed [32:0] sum_re;
   logic signed [32:0] sum_im;

   // Extra bit keeps the pair sum from wrapping
   assign sum_re = {first_r.re[31], first_r.re} + {in_smp.re[31], in_smp.re};
   assign sum_im = {first_r.im[31], first_r.im} + {in_smp.im[31], in_smp.im};

   // Pair average halves both rate and bandwidth
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_r <= 1'b0;
         first_r <= '0;
         out_valid <= 1'b0;
         out_smp <= '0;
      end else if (flush) begin
         phase_r <= 1'b0;
         out_valid <= 1'b0;
      end else begin
         out_valid <= in_valid & phase_r;
         if (in_valid) begin
            phase_r <= ~phase_r;
            if (!phase_r) first_r <= in_smp;
            else out_smp <= '{re: sum_re[32:1], im: sum_im[32:1]};
         end
      end
   end
endmodule

// *** core/cdf_packer.sv ***
// Output word formatter: places samples and pass tag in 32-bit words.
// Assumes at most one sample offered per clock; output is registered.
`timescale 1ns/1ps
module cdf_packer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic in_valid,
   input cdf_pkg::cdf_smp_t in_smp,
   input wire logic [cdf_pkg::TAG_W-1:0] tag,
   input wire logic multi,
   input wire logic tag_hi,
   input wire logic size16,
   input wire logic cplx,
   output logic out_valid,
   output cdf_pkg::cdf_word_t out_word
);
   localparam int H = cdf_pkg::HALF;
   localparam int T = cdf_pkg::TAG_W;
   localparam int L = cdf_pkg::TAG24_LSB;
   cdf_pkg::cdf_word_t w_nxt;

   // Format select; tag position only matters in multi-pass
   always_comb begin
      w_nxt = '0;
      if (cplx && !size16) begin
         w_nxt = '{w0: in_smp.re, w1: in_smp.im, two: 1'b1};
      end else if (cplx) begin
         w_nxt.w0 = {in_smp.re[31:H], in_smp.im[31:H]};
         if (multi) w_nxt.w0[T-1:0] = tag; // R22
      end else if (size16) begin
         w_nxt.w0 = {in_smp.re[31:H], {H{1'b0}}};
         if (multi) w_nxt.w0[T-1:0] = tag; // R19
      end else begin
         w_nxt.w0 = in_smp.re;
         if (multi && tag_hi) w_nxt.w0[L+T-1:L] = tag; // R21
         else if (multi) w_nxt.w0[T-1:0] = tag; // R20
      end
   end

   // Registered so data leaves straight from flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_valid <= 1'b0;
         out_word <= '0;
      end else begin
         out_valid <= in_valid;
         if (in_valid) out_word <= w_nxt;
      end
   end
endmodule

// *** core/cdf_pkg.sv ***
// Shared constants and carriers for the cascaded decimation filter.
// Assumes one APB clock domain; all users refer to names as cdf_pkg::name.
package cdf_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_LEVEL = 8'h00;
   localparam logic [7:0] OFF_DATA_BW = 8'h04;
   localparam logic [7:0] OFF_TRIG_BW = 8'h08;
   localparam logic [7:0] OFF_MODE = 8'h0C;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_CMD = 8'h14;
   // Mode register field positions; extra, output and tag fields two bits, size and complex one bit each
   localparam int MODE_EXTRA_LSB = 0;
   localparam int MODE_OUT_LSB = 2;
   localparam int MODE_TAG_LSB = 4;
   localparam int MODE_SIZE16_BIT = 6;
   localparam int MODE_CPLX_BIT = 7;
   // Status and command bits
   localparam int ST_RUN_BIT = 0;
   localparam int ST_ERR_BIT = 1;
   localparam int ST_RATE_LSB = 8;
   localparam int ST_BW_LSB = 16;
   localparam int CMD_START_BIT = 0;
   localparam int CMD_STOP_BIT = 1;
   localparam int LVL_SIGN_BIT = 15;
   // Field encodings; anything else is ignored
   localparam logic [1:0] ENC_OFF = 2'h0;
   localparam logic [1:0] ENC_ON = 2'h1;
   // Level limits and sizes
   localparam logic [4:0] LEVEL_MAX = 5'h18;
   localparam logic [4:0] LEVEL_MAX_EXTRA = 5'h17;
   localparam int TAG_W = 5;
   localparam int SECTIONS = 24;
   localparam int IN_WIDTH = 24;
   localparam int HALF = 16;
   localparam int TAG24_LSB = 8;
   // One complex sample, 32-bit signed parts
   typedef struct packed {
      logic signed [31:0] re;
      logic signed [31:0] im;
   } cdf_smp_t;
   // Output beat: one or two 32-bit words
   typedef struct packed {
      logic [31:0] w0;
      logic [31:0] w1;
      logic two;
   } cdf_word_t;
endpackage

// *** core/cdf_top.sv ***
// Cascaded decimation filter: APB registers, halving cascade, pass mux.
// Assumes samples come from pclk logic, at most one every two clocks.
//
// Functional notes
// R1 - Decimating by N keeps one of every N samples, with matching bandwidth cut.
// R2 - Any decimation setting change while running returns the block to idle.
// R3 - Writing the combined level sets data and trigger bandwidth equal.
// R4 - Level zero bypasses all digital filtering.
// R5 - Levels above 24 clamp to 24.
// R6 - With extra halving on, levels of 24 drop to 23.
// R7 - Negative level values are rejected as illegal.
// R8 - Extra halving drops every other output; off keeps every output.
// R9 - Level zero rate is input rate over two to the extra bit.
// R10 - Nonzero level rate is input over two to level plus extra minus one.
// R11 - Baseband bandwidth is half the output rate; zoomed equals it.
// R12 - Real data means baseband; complex data means zoomed.
// R13 - The filter is a cascade of sections each halving rate and bandwidth.
// R14 - Single-pass emits only the final used section.
// R15 - Multi-pass multiplexes every section at or below programmed bandwidth.
// R16 - Multi-pass is only available at bandwidth level zero.
// R17 - Multi-pass samples carry a five-bit pass number.
// R18 - Tag position is ignored in single-pass output.
// R19 - Real 16-bit tag sits in an extra zeroed half-word, no data lost.
// R20 - Low tag position overwrites the five lowest bits of 32-bit real.
// R21 - Upper-24 tag position puts the tag at bits above the low byte.
// R22 - Complex 16-bit words hold real high, imaginary low, tag lowest.
// R23 - Pass number is the producing section index from the chain start.
// R24 - Invalid extra, output or tag encodings are ignored.
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module cdf_top #(
   parameter int NSEC = cdf_pkg::SECTIONS,
   parameter int IN_W = cdf_pkg::IN_WIDTH
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic in_valid,
   input wire logic signed [IN_W-1:0] in_re,
   input wire logic signed [IN_W-1:0] in_im,
   output logic out_valid,
   output cdf_pkg::cdf_word_t out_word,
   output logic [4:0] trig_bw,
   output logic running
);
   localparam int T = cdf_pkg::TAG_W;

   logic [4:0] data_bw_r;
   logic [4:0] trig_bw_r;
   logic extra_r;
   logic multi_r;
   logic tag_hi_r;
   logic size16_r;
   logic cplx_r;
   logic running_r;
   logic bw_err_r;
   logic [31:0] prdata_r;
   logic wr_en;
   logic rd_setup;
   logic mapped;
   logic cfg_wr;
   logic neg_val;
   logic [1:0] f_extra;
   logic [1:0] f_out;
   logic [1:0] f_tag;
   logic [4:0] tap_idx;
   logic [4:0] rate_exp;
   logic [4:0] bw_exp;
   logic multi_eff;
   logic flush;

   // Level clamp: 24 normally, 23 with extra halving on
   function automatic logic [4:0] clamp_bw(input logic [15:0] v, input logic ext);
      logic [4:0] lim;
      lim = ext ? cdf_pkg::LEVEL_MAX_EXTRA : cdf_pkg::LEVEL_MAX;
      if (v > 16'(lim)) return lim; // R5 R6
      return v[4:0];
   endfunction

   // APB decode; zero wait states, errors on unmapped offsets
   assign wr_en = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign mapped = (paddr == cdf_pkg::OFF_LEVEL) || (paddr == cdf_pkg::OFF_DATA_BW) ||
                   (paddr == cdf_pkg::OFF_TRIG_BW) || (paddr == cdf_pkg::OFF_MODE) ||
                   (paddr == cdf_pkg::OFF_STATUS) || (paddr == cdf_pkg::OFF_CMD);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata = prdata_r;
   assign cfg_wr = wr_en && ((paddr == cdf_pkg::OFF_LEVEL) || (paddr == cdf_pkg::OFF_DATA_BW) ||
                   (paddr == cdf_pkg::OFF_TRIG_BW) || (paddr == cdf_pkg::OFF_MODE));
   assign neg_val = pwdata[cdf_pkg::LVL_SIGN_BIT];
   assign f_extra = pwdata[cdf_pkg::MODE_EXTRA_LSB +: 2];
   assign f_out = pwdata[cdf_pkg::MODE_OUT_LSB +: 2];
   assign f_tag = pwdata[cdf_pkg::MODE_TAG_LSB +: 2];

   // Bandwidth levels; negative writes leave them untouched
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_bw_r <= '0;
         trig_bw_r <= '0;
      end else if (wr_en && !neg_val) begin // R7
         case (paddr)
            cdf_pkg::OFF_LEVEL: begin
               data_bw_r <= clamp_bw(pwdata[15:0], extra_r); // R3
               trig_bw_r <= clamp_bw(pwdata[15:0], extra_r); // R3
            end
            cdf_pkg::OFF_DATA_BW: data_bw_r <= clamp_bw(pwdata[15:0], extra_r);
            cdf_pkg::OFF_TRIG_BW: trig_bw_r <= clamp_bw(pwdata[15:0], extra_r);
            cdf_pkg::OFF_MODE: begin
               // Turning extra on pulls 24 down so total stays 24
               if (f_extra == cdf_pkg::ENC_ON && data_bw_r == cdf_pkg::LEVEL_MAX) begin
                  data_bw_r <= cdf_pkg::LEVEL_MAX_EXTRA; // R6
               end
               if (f_extra == cdf_pkg::ENC_ON && trig_bw_r == cdf_pkg::LEVEL_MAX) begin
                  trig_bw_r <= cdf_pkg::LEVEL_MAX_EXTRA; // R6
               end
            end
            default: ;
         endcase
      end
   end

   // Mode fields; only the two legal codes are accepted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         extra_r <= 1'b0;
         multi_r <= 1'b0;
         tag_hi_r <= 1'b0;
         size16_r <= 1'b0;
         cplx_r <= 1'b0;
      end else if (wr_en && paddr == cdf_pkg::OFF_MODE) begin
         if (f_extra == cdf_pkg::ENC_ON || f_extra == cdf_pkg::ENC_OFF) extra_r <= f_extra[0]; // R24
         if (f_out == cdf_pkg::ENC_ON || f_out == cdf_pkg::ENC_OFF) multi_r <= f_out[0]; // R24
         if (f_tag == cdf_pkg::ENC_ON || f_tag == cdf_pkg::ENC_OFF) tag_hi_r <= f_tag[0]; // R24
         size16_r <= pwdata[cdf_pkg::MODE_SIZE16_BIT];
         cplx_r <= pwdata[cdf_pkg::MODE_CPLX_BIT]; // R12
      end
   end

   // Run state; a config write mid-run wins over a start
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         running_r <= 1'b0;
      end else if (cfg_wr) begin
         running_r <= 1'b0; // R2
      end else if (wr_en && paddr == cdf_pkg::OFF_CMD) begin
         if (pwdata[cdf_pkg::CMD_STOP_BIT]) running_r <= 1'b0;
         else if (pwdata[cdf_pkg::CMD_START_BIT]) running_r <= 1'b1;
      end
   end

   // Sticky illegal-level flag; a new error beats the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bw_err_r <= 1'b0;
      end else if (wr_en && neg_val && (paddr == cdf_pkg::OFF_LEVEL ||
                   paddr == cdf_pkg::OFF_DATA_BW || paddr == cdf_pkg::OFF_TRIG_BW)) begin
         bw_err_r <= 1'b1; // R7
      end else if (wr_en && paddr == cdf_pkg::OFF_STATUS && pwdata[cdf_pkg::ST_ERR_BIT]) begin
         bw_err_r <= 1'b0;
      end
   end

   // Rate and bandwidth exponents reported to software
   assign tap_idx = (data_bw_r == '0) ? '0 : data_bw_r - 5'h01; // R4 R10
   assign rate_exp = tap_idx + {4'h0, extra_r}; // R9 R10
   assign bw_exp = rate_exp + {4'h0, ~cplx_r}; // R11 R12
   assign multi_eff = multi_r && (data_bw_r == '0); // R16
   assign flush = ~running_r;
   assign trig_bw = trig_bw_r;
   assign running = running_r;

   // Read data captured in the setup phase, ready at access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= '0;
      end else if (rd_setup) begin
         prdata_r <= '0;
         case (paddr)
            cdf_pkg::OFF_LEVEL, cdf_pkg::OFF_DATA_BW: prdata_r[4:0] <= data_bw_r;
            cdf_pkg::OFF_TRIG_BW: prdata_r[4:0] <= trig_bw_r;
            cdf_pkg::OFF_MODE: begin
               prdata_r[cdf_pkg::MODE_EXTRA_LSB] <= extra_r;
               prdata_r[cdf_pkg::MODE_OUT_LSB] <= multi_r;
               prdata_r[cdf_pkg::MODE_TAG_LSB] <= tag_hi_r;
               prdata_r[cdf_pkg::MODE_SIZE16_BIT] <= size16_r;
               prdata_r[cdf_pkg::MODE_CPLX_BIT] <= cplx_r;
            end
            cdf_pkg::OFF_STATUS: begin
               prdata_r[cdf_pkg::ST_RUN_BIT] <= running_r;
               prdata_r[cdf_pkg::ST_ERR_BIT] <= bw_err_r;
               prdata_r[cdf_pkg::ST_RATE_LSB +: 5] <= rate_exp;
               prdata_r[cdf_pkg::ST_BW_LSB +: 5] <= bw_exp;
            end
            default: ;
         endcase
      end
   end

   // Cascade taps: tap 0 is the raw input, tap k follows section k
   cdf_pkg::cdf_smp_t tap_d [0:NSEC];
   logic tap_v [0:NSEC];
   logic keep_r [0:NSEC];
   logic pend_r [0:NSEC];
   cdf_pkg::cdf_smp_t hold_r [0:NSEC];
   logic fire [0:NSEC];
   logic grant [0:NSEC];
   logic [4:0] gnt_idx;
   logic gnt_any;

   // Input stage; widened to 32 bits with low bits zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tap_v[0] <= 1'b0;
         tap_d[0] <= '0;
      end else begin
         tap_v[0] <= in_valid & running_r; // R4
         if (in_valid) begin
            tap_d[0].re <= {in_re, {(32-IN_W){1'b0}}};
            tap_d[0].im <= {in_im, {(32-IN_W){1'b0}}};
         end
      end
   end

   genvar k;
   generate
      for (k = 1; k <= NSEC; k++) begin : g_sec
         // Each section halves rate and band of the one before
         cdf_halver u_sec (
            .pclk(pclk),
            .presetn(presetn),
            .flush(flush),
            .in_valid(tap_v[k-1]),
            .in_smp(tap_d[k-1]),
            .out_valid(tap_v[k]),
            .out_smp(tap_d[k])
         ); // R13 R1
      end
      for (k = 0; k <= NSEC; k++) begin : g_tap
         logic en;
         // Single-pass takes one tap; multi-pass takes them all
         assign en = multi_eff ? 1'b1 : (tap_idx == 5'(k)); // R14 R15
         assign fire[k] = tap_v[k] & en & (~extra_r | keep_r[k]); // R8
         assign grant[k] = gnt_any && (gnt_idx == 5'(k));

         // Extra halving keeps the second of each pair
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) keep_r[k] <= 1'b0;
            else if (flush) keep_r[k] <= 1'b0;
            else if (tap_v[k]) keep_r[k] <= ~keep_r[k]; // R8
         end

         // Per-tap holding slot; a fresh sample beats its grant
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pend_r[k] <= 1'b0;
               hold_r[k] <= '0;
            end else if (fire[k]) begin
               pend_r[k] <= 1'b1;
               hold_r[k] <= tap_d[k];
            end else if (grant[k] || flush) begin
               pend_r[k] <= 1'b0;
            end
         end
      end
   endgenerate

   // Lowest pending tap goes first; wider bands are most frequent
   always_comb begin
      gnt_idx = '0;
      gnt_any = 1'b0;
      for (int i = NSEC; i >= 0; i--) begin
         if (pend_r[i]) begin
            gnt_idx = 5'(i); // R23
            gnt_any = 1'b1;
         end
      end
   end

   cdf_packer u_pack (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(gnt_any & running_r),
      .in_smp(hold_r[gnt_idx]),
      .tag(gnt_idx[T-1:0]), // R17 R23
      .multi(multi_eff), // R18
      .tag_hi(tag_hi_r),
      .size16(size16_r),
      .cplx(cplx_r),
      .out_valid(out_valid),
      .out_word(out_word)
   );

   // Checks beside the logic
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_level_both_equal: assert property ( // R3
      wr_en && paddr == cdf_pkg::OFF_LEVEL && !neg_val |=> data_bw_r == trig_bw_r)
      else $error("level write left data and trigger bandwidth different");
   a_level_clamp_max: assert property ( // R5
      wr_en && paddr == cdf_pkg::OFF_LEVEL && !neg_val && !extra_r && pwdata[15:0] > 16'h0018
      |=> data_bw_r == cdf_pkg::LEVEL_MAX)
      else $error("level above limit not clamped to 24");
   a_extra_limit_23: assert property ( // R6
      extra_r |-> data_bw_r <= cdf_pkg::LEVEL_MAX_EXTRA && trig_bw_r <= cdf_pkg::LEVEL_MAX_EXTRA)
      else $error("extra halving with level above 23");
   a_negative_rejected: assert property ( // R7
      wr_en && neg_val && (paddr == cdf_pkg::OFF_LEVEL || paddr == cdf_pkg::OFF_DATA_BW)
      |=> $stable(data_bw_r) && bw_err_r)
      else $error("negative level accepted or not flagged");
   a_idle_on_change: assert property ( // R2
      running_r && cfg_wr |=> !running_r)
      else $error("setting change did not force idle");
   // Off level zero only the selected tap may win, whatever the stored mode bit says
   a_multi_bw_zero: assert property ( // R16
      gnt_any && running_r && data_bw_r != '0 |-> gnt_idx == tap_idx)
      else $error("multi-pass output at nonzero bandwidth");
   a_bypass_latency: assert property ( // R4
      in_valid && running_r && !extra_r && data_bw_r == '0 && !multi_eff && !cfg_wr
      ##1 running_r && !in_valid ##1 !in_valid |=> out_valid)
      else $error("level zero sample not passed in three cycles");
   a_low_tag_place: assert property ( // R20
      gnt_any && running_r && multi_eff && !tag_hi_r && !size16_r && !cplx_r
      |=> out_valid && out_word.w0[T-1:0] == $past(gnt_idx))
      else $error("pass tag not in low five bits");
   a_single_no_tag: assert property ( // R18
      gnt_any && running_r && !multi_eff && !size16_r && !cplx_r
      |=> out_word.w0 == $past(hold_r[gnt_idx].re))
      else $error("single-pass word altered by tag");
   a_extra_drops_half: assert property ( // R8
      tap_v[0] && extra_r && !keep_r[0] && data_bw_r == '0 && !multi_eff |=> !pend_r[0])
      else $error("extra halving kept a dropped sample");

   c_multi_out: cover property (out_valid && multi_eff && gnt_idx != '0);
   c_extra_out: cover property (out_valid && extra_r);
   c_clamp_hit: cover property (data_bw_r == cdf_pkg::LEVEL_MAX);
   c_neg_write: cover property (wr_en && neg_val);
endmodule

// *** tb/cascaded_decimation_filter_tb.sv ***
// Self-checking bench for the decimation filter: APB register tasks plus sample feeds.
// Assumes zero-wait APB slave and a host model that queues every output word.
`timescale 1ns/1ps
module cascaded_decimation_filter_tb;
   logic pclk, presetn, psel, penable, pwrite, in_valid;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic pready, pslverr, out_valid, running, e;
   logic signed [23:0] in_re, in_im;
   logic [4:0] trig_bw;
   cdf_pkg::cdf_word_t out_word;
   int errors = 0;
   int check_count = 0;
   int cycles = 0;
   logic [31:0] base [4] = '{32'h12345600, 32'h12344000, 32'h12340000, 32'h123400A0};
   logic [31:0] modes [4] = '{32'h04, 32'h14, 32'h44, 32'hC4};
   int sh [4] = '{0, 8, 0, 0};

   cdf_top #(.NSEC(24), .IN_W(24)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .in_valid(in_valid), .in_re(in_re), .in_im(in_im), .out_valid(out_valid),
      .out_word(out_word), .trig_bw(trig_bw), .running(running)
   );
   cdf_host_model host (.pclk(pclk), .out_valid(out_valid), .out_word(out_word));

   // 10 MHz clock
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // Hang guard, well above the roughly nine hundred cycles the tests need
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr_en;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(r, exp);
   endtask

   // One sample, then a long gap so every pending tap drains
   task automatic feed(input logic [23:0] re, input logic [23:0] im);
      @(posedge pclk);
      in_valid <= 1'b1;
      in_re <= re;
      in_im <= im;
      @(posedge pclk);
      in_valid <= 1'b0;
      repeat (40) @(posedge pclk);
   endtask

   // Configure, then start; config writes stop the run, so start comes last
   task automatic setup(input logic [31:0] lvl, input logic [31:0] mode);
      wr(cdf_pkg::OFF_LEVEL, lvl);
      wr(cdf_pkg::OFF_MODE, mode);
      wr(cdf_pkg::OFF_CMD, 32'h1);
      host.q.delete();
   endtask

   // Main sequence
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      in_valid = 1'b0;
      in_re = 24'h0;
      in_im = 24'h0;
      presetn = 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdc(cdf_pkg::OFF_LEVEL, 32'h0);
      rdc(cdf_pkg::OFF_MODE, 32'h0);
      rdc(cdf_pkg::OFF_STATUS, 32'h00010000);
      apb(1'b0, 8'h40, 32'h0);
      chk({31'h0, e}, 32'h1);
      chk(r, 32'h0);
      // Clamping and shared trigger level
      wr(cdf_pkg::OFF_LEVEL, 32'h1E);
      rdc(cdf_pkg::OFF_LEVEL, 32'h18);
      chk({27'h0, trig_bw}, 32'h18);
      wr(cdf_pkg::OFF_MODE, 32'h1);
      rdc(cdf_pkg::OFF_LEVEL, 32'h17);
      chk({27'h0, trig_bw}, 32'h17);
      wr(cdf_pkg::OFF_MODE, 32'h2A);
      rdc(cdf_pkg::OFF_MODE, 32'h1);
      wr(cdf_pkg::OFF_LEVEL, 32'hFFFF);
      rdc(cdf_pkg::OFF_LEVEL, 32'h17);
      apb(1'b0, cdf_pkg::OFF_STATUS, 32'h0);
      chk(r & 32'h2, 32'h2);
      wr(cdf_pkg::OFF_STATUS, 32'h2);
      // A setting change mid-run must drop back to idle
      wr(cdf_pkg::OFF_CMD, 32'h1);
      #10 chk({31'h0, running}, 32'h1);
      wr(cdf_pkg::OFF_DATA_BW, 32'h0);
      #10 chk({31'h0, running}, 32'h0);
      // Level zero bypass, tag position set but single-pass
      setup(32'h0, 32'h10);
      feed(24'h123456, 24'h0);
      feed(24'h7FFF01, 24'h0);
      chk(32'(host.q.size()), 32'h2);
      chk(host.q[0].w0, 32'h12345600);
      chk(host.q[1].w0, 32'h7FFF0100);
      // Extra halving keeps the second of each pair
      setup(32'h0, 32'h1);
      for (int i = 0; i < 4; i++) feed(24'((i + 1) * 256), 24'h0);
      chk(32'(host.q.size()), 32'h2);
      chk(host.q[0].w0, 32'h00020000);
      chk(host.q[1].w0, 32'h00040000);
      apb(1'b0, cdf_pkg::OFF_STATUS, 32'h0);
      chk(r & 32'h1F1F00, 32'h00020100);
      // Level two: one halving section; multi-pass ignored off level zero
      setup(32'h2, 32'h84);
      for (int i = 0; i < 4; i++) feed(i % 2 == 1 ? 24'h000300 : 24'h000100, 24'h000200);
      chk(32'(host.q.size()), 32'h2);
      chk(host.q[0].w0, 32'h00020000);
      chk(host.q[1].w0, 32'h00020000);
      chk(host.q[0].w1, 32'h00020000);
      chk({31'h0, host.q[1].two}, 32'h1);
      apb(1'b0, cdf_pkg::OFF_STATUS, 32'h0);
      chk(r & 32'h1F1F00, 32'h00010100);
      // Multi-pass formats: two raw taps then one first-section tap
      for (int k = 0; k < 4; k++) begin
         setup(32'h0, modes[k]);
         feed(24'h123456, 24'h00ABCD);
         feed(24'h123456, 24'h00ABCD);
         chk(32'(host.q.size()), 32'h3);
         chk({31'h0, host.q[2].two}, 32'h0);
         for (int j = 0; j < 3; j++) chk(host.q[j].w0, base[k] | (32'(j / 2) << sh[k]));
      end
      complete_run();
   end
endmodule

// *** tb/cdf_host_model.sv ***
// Host side model: collects every output word that the filter emits.
// Assumes out_valid is a one-cycle pulse in the pclk domain, with no back-pressure.
`timescale 1ns/1ps
module cdf_host_model (
   input wire logic pclk,
   input wire logic out_valid,
   input cdf_pkg::cdf_word_t out_word
);
   cdf_pkg::cdf_word_t q[$];
   // Capture at the edge the pulse is seen; a missed pulse would be lost for good
   always @(posedge pclk) begin
      if (out_valid === 1'b1) begin
         q.push_back(out_word);
      end
   end
endmodule
